// file: logic/iau_defines.vh
// What this block does
// - pointer high byte bit 7 set routes window access to program flash.
// - indirect read of flash returns only low eight bits of the word.
// - writes through a pointer into program flash change nothing.
// - flash read through the pointer costs one extra instruction cycle.
// - window registers store nothing; accesses go to the pointed location.
// - pointer at a window register: read gives zero, write suppressed.
// - pointer is high byte concatenated above low byte.
// - 16-bit pointer, 65536 locations, three regions.
// - pointer 0x000 to 0xFFF maps to absolute data register addresses.
// - pointer wraps at 0000h and FFFFh on increment or decrement.
// - automatic pointer steps leave status flags unchanged.
`ifndef IAU_DEFINES_VH
`define IAU_DEFINES_VH
`define IAU_FLASH_BIT 15
`define IAU_TRAD_TOP 16'h0FFF
`define IAU_WIN0_ADDR 16'h0000
`define IAU_WIN1_ADDR 16'h0001
`define IAU_LIN_BASE 16'h2000
`define IAU_LIN_SIZE 16'h6000
`define IAU_PTR_RESET 16'h0000
`define IAU_EXTRA_CYCLES 1
`define IAU_MODE_PREINC 2'h0
`define IAU_MODE_PREDEC 2'h1
`define IAU_MODE_POSTINC 2'h2
`define IAU_MODE_POSTDEC 2'h3
`define IAU_REGION_TRAD 2'h0
`define IAU_REGION_LIN 2'h1
`define IAU_REGION_FLASH 2'h2
`define IAU_REGION_NONE 2'h3
`endif

// file: logic/iau_region_decode.v
`timescale 1ns/1ns
`include "iau_defines.vh"
module iau_region_decode
(
	input wire [15:0] pointer,
	output reg [1:0] region,
	output wire isWindow,
	output reg [15:0] mappedAddr
);
	// ==============================
	// region decode
	// window registers themselves are caught first
	assign isWindow = (pointer == `IAU_WIN0_ADDR) || (pointer == `IAU_WIN1_ADDR);
	always @*
	begin
		region = `IAU_REGION_NONE;
		mappedAddr = 16'h0000;
		if (pointer[`IAU_FLASH_BIT])
		begin
			region = `IAU_REGION_FLASH;
			mappedAddr = {1'b0, pointer[14:0]};
		end
		else if (pointer <= `IAU_TRAD_TOP)
		begin
			region = `IAU_REGION_TRAD;
			mappedAddr = pointer;
		end
		else if ((pointer >= `IAU_LIN_BASE) && (pointer < (`IAU_LIN_BASE + `IAU_LIN_SIZE)))
		begin
			region = `IAU_REGION_LIN;
			mappedAddr = pointer - `IAU_LIN_BASE;
		end
	end
endmodule

// file: logic/iau_indirect_address_unit.v
`timescale 1ns/1ns
`include "iau_defines.vh"
module iau_indirect_address_unit
(
	input wire clk,
	input wire reset_n,
	input wire clkEnable,
	// pointer byte loads from core
	input wire ptrSel,
	input wire loadHigh,
	input wire loadLow,
	input wire [7:0] loadData,
	// indirect access request
	input wire accessValid,
	input wire accessWrite,
	input wire accessSel,
	input wire useMode,
	input wire [1:0] stepMode,
	input wire [5:0] offset,
	input wire [7:0] writeData,
	// data memory port
	output reg dataRead,
	output reg dataWrite,
	output reg [15:0] dataAddr,
	output reg [7:0] dataWriteValue,
	input wire [7:0] dataReadValue,
	output reg linearAccess,
	// program flash port
	output reg flashRead,
	output reg [14:0] flashAddr,
	input wire [13:0] flashWord,
	// result
	output wire stall,
	output reg resultValid,
	output reg [7:0] resultData,
	output reg zeroFlag,
	output reg flagUpdate,
	output reg [15:0] pointer0,
	output reg [15:0] pointer1
);
	localparam IDLE = 2'h0;
	localparam FLASH_WAIT = 2'h1;
	localparam FLASH_DONE = 2'h2;

	reg [1:0] state;
	reg [15:0] basePtr;
	reg [15:0] effPtr;
	reg [15:0] next_ptr;
	reg heldSel;
	wire [1:0] region;
	wire isWindow;
	wire [15:0] mappedAddr;

	// ==============================
	// pointer arithmetic
	function [15:0] stepPointer;
		input [15:0] ptr;
		input [1:0] mode;
		begin
			// 16-bit sums wrap naturally at both ends
			if ((mode == `IAU_MODE_PREINC) || (mode == `IAU_MODE_POSTINC))
				stepPointer = ptr + 16'h0001;
			else
				stepPointer = ptr - 16'h0001;
		end
	endfunction

	// effective address and updated pointer for current request
	always @*
	begin
		basePtr = accessSel ? pointer1 : pointer0;
		effPtr = basePtr;
		next_ptr = basePtr;
		if (useMode)
		begin
			next_ptr = stepPointer(basePtr, stepMode);
			if ((stepMode == `IAU_MODE_PREINC) || (stepMode == `IAU_MODE_PREDEC))
				effPtr = next_ptr;
		end
		else
			effPtr = basePtr + {{10{offset[5]}}, offset};
	end

	iau_region_decode decoder
	(
		.pointer(effPtr),
		.region(region),
		.isWindow(isWindow),
		.mappedAddr(mappedAddr)
	);

	// extra cycle while flash is read
	assign stall = (state == FLASH_WAIT);

	// ==============================
	// pointer registers and access sequencing
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= IDLE;
			pointer0 <= `IAU_PTR_RESET;
			pointer1 <= `IAU_PTR_RESET;
			heldSel <= 1'b0;
			dataRead <= 1'b0;
			dataWrite <= 1'b0;
			dataAddr <= 16'h0000;
			dataWriteValue <= 8'h00;
			linearAccess <= 1'b0;
			flashRead <= 1'b0;
			flashAddr <= 15'h0000;
			resultValid <= 1'b0;
			resultData <= 8'h00;
			zeroFlag <= 1'b0;
			flagUpdate <= 1'b0;
		end
		else if (clkEnable)
		begin
			dataRead <= 1'b0;
			dataWrite <= 1'b0;
			flashRead <= 1'b0;
			resultValid <= 1'b0;
			flagUpdate <= 1'b0;
			case (state)
			IDLE:
			begin
				// byte loads compose the pointer
				if (loadHigh && !ptrSel)
					pointer0[15:8] <= loadData;
				if (loadLow && !ptrSel)
					pointer0[7:0] <= loadData;
				if (loadHigh && ptrSel)
					pointer1[15:8] <= loadData;
				if (loadLow && ptrSel)
					pointer1[7:0] <= loadData;
				if (accessValid)
				begin
					heldSel <= accessSel;
					// stepping touches no flag output
					if (accessSel)
						pointer1 <= next_ptr;
					else
						pointer0 <= next_ptr;
					linearAccess <= (region == `IAU_REGION_LIN);
					if (isWindow)
					begin
						// window reads give zero, writes dropped
						if (!accessWrite)
						begin
							resultValid <= 1'b1;
							resultData <= 8'h00;
							zeroFlag <= 1'b1;
							flagUpdate <= 1'b1;
						end
					end
					else if (region == `IAU_REGION_FLASH)
					begin
						// flash writes are silently ignored
						if (!accessWrite)
						begin
							flashRead <= 1'b1;
							flashAddr <= mappedAddr[14:0];
							state <= FLASH_WAIT;
						end
					end
					else if (region != `IAU_REGION_NONE)
					begin
						// redirect to pointed location
						dataAddr <= mappedAddr;
						dataWriteValue <= writeData;
						dataWrite <= accessWrite;
						dataRead <= !accessWrite;
						if (!accessWrite)
							state <= FLASH_DONE;
					end
					else if (!accessWrite)
					begin
						resultValid <= 1'b1;
						resultData <= 8'h00;
						zeroFlag <= 1'b1;
						flagUpdate <= 1'b1;
					end
				end
			end
			FLASH_WAIT:
			begin
				// low byte of program word only
				resultValid <= 1'b1;
				resultData <= flashWord[7:0];
				zeroFlag <= (flashWord[7:0] == 8'h00);
				flagUpdate <= 1'b1;
				state <= IDLE;
			end
			FLASH_DONE:
			begin
				resultValid <= 1'b1;
				resultData <= dataReadValue;
				zeroFlag <= (dataReadValue == 8'h00);
				flagUpdate <= 1'b1;
				state <= IDLE;
			end
			default:
				state <= IDLE;
			endcase
		end
	end
endmodule

// file: tb/iau_mem_model.sv
`timescale 1ns/1ns
// far-side memory: answers while read, scrambles otherwise
module iau_mem_model
(
	input wire dataRead,
	input wire [15:0] dataAddr,
	input wire flashRead,
	input wire [14:0] flashAddr,
	output wire [7:0] dataReadValue,
	output wire [13:0] flashWord
);
	wire [7:0] d = dataAddr[7:0] ^ dataAddr[15:8];
	wire [13:0] f = flashAddr[13:0] ^ 14'h15A5;
	assign dataReadValue = dataRead ? d : ~d;
	assign flashWord = flashRead ? f : ~f;
endmodule

// file: tb/iau_sva.sv
`timescale 1ns/1ns
module iau_sva
(
	input clk, reset_n, clkEnable, accessValid, accessWrite, accessSel, useMode,
	input [1:0] stepMode,
	input [7:0] writeData, dataReadValue, dataWriteValue, resultData,
	input [13:0] flashWord,
	input [14:0] flashAddr,
	input [15:0] dataAddr, pointer0, pointer1,
	input dataRead, dataWrite, linearAccess, flashRead, stall, resultValid, zeroFlag, flagUpdate
);
	// accepted post-step request: the pointer itself is the address
	wire [15:0] p = accessSel ? pointer1 : pointer0;
	wire go = clkEnable && accessValid && useMode && stepMode[1] && !dataRead && !flashRead;
	wire rd = go && !accessWrite;
	wire wr = go && accessWrite;
	wire trad = p > 16'h0001 && p < 16'h1000;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	flash_route_a: assert property (
		rd && p[15] |=> flashRead && stall && !dataRead && flashAddr == $past(p[14:0])) else $error("flash route");
	flash_result_a: assert property (
		flashRead && clkEnable |=> resultValid && resultData == $past(flashWord[7:0])) else $error("flash byte");
	freeze_hold_a: assert property (
		!clkEnable |=> pointer0 == $past(pointer0) && pointer1 == $past(pointer1) && resultValid == $past(resultValid))
		else $error("freeze");
	flash_nowrite_a: assert property (
		wr && p[15] |=> !dataWrite && !flashRead) else $error("flash write");
	trad_write_a: assert property (
		wr && trad |=> dataWrite && !linearAccess && dataAddr == $past(p) && dataWriteValue == $past(writeData))
		else $error("trad write");
	window_read_a: assert property (
		rd && p < 16'h0002 |=> resultValid && resultData == 8'h00 && zeroFlag && !dataRead) else $error("window read");
	linear_write_a: assert property (
		wr && !p[15] && p >= 16'h2000 |=> dataWrite && linearAccess && dataAddr == $past(p) - 16'h2000)
		else $error("linear write");
	step_wrap_a: assert property (
		go && !accessSel |=> pointer0 == $past(pointer0 + (stepMode[0] ? 16'hFFFF : 16'h0001))) else $error("step");
	step_flags_a: assert property (
		wr && p > 16'h0001 |=> !flagUpdate) else $error("flags");
	data_read_a: assert property (
		rd && trad |=> dataRead ##1 resultValid && !stall && resultData == $past(dataReadValue)) else $error("read");
endmodule
bind iau_indirect_address_unit iau_sva chk (.*);

// file: tb/testbench.sv
`timescale 1ns/1ns
// ==========
// bench: corner and random indirect accesses
module testbench;
	reg clk = 0, reset_n = 0, clkEnable = 1, ptrSel = 0, loadHigh = 0, loadLow = 0;
	reg accessValid = 0, accessWrite = 0, accessSel = 0, useMode = 0;
	reg [1:0] stepMode = 0;
	reg [5:0] offset = 0;
	reg [7:0] loadData = 0, writeData = 0, lastRes = 0;
	wire [7:0] dataReadValue, dataWriteValue, resultData;
	wire [13:0] flashWord;
	wire [14:0] flashAddr;
	wire [15:0] dataAddr, pointer0, pointer1;
	wire dataRead, dataWrite, linearAccess, flashRead, stall, resultValid, zeroFlag, flagUpdate;
	reg [31:0] rnd = 32'h7769E86C, mismatches = 0, total_checks = 0;
	reg [15:0] a;
	integer i;
	iau_indirect_address_unit dut (.*);
	iau_mem_model mem (.*);
	always #5 clk = ~clk;
	// capture each result pulse
	always @(posedge clk) if (resultValid === 1'b1) lastRes <= resultData;
	function [31:0] xs(input [31:0] v);
	begin
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		xs = v ^ (v << 5);
	end
	endfunction
	// expected byte read from an address
	function [7:0] er(input [15:0] x);
		er = x[15] ? x[7:0] ^ 8'hA5 : (x < 16'h0002 || x[15:12] == 4'h1) ? 8'h00
			: x[7:0] ^ (x[15:8] - ((x[13] | x[14]) ? 8'h20 : 8'h00));
	endfunction
	task chk(input [15:0] g, input [15:0] e);
	begin
		total_checks = total_checks + 1;
		if (g !== e)
		begin
			mismatches = mismatches + 1;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	end
	endtask
	// load a pointer, make one access, compare pointer and result
	task op(input s, input w, input u, input [1:0] m, input [5:0] o, input [15:0] v);
	begin
		// a load offered while frozen must be dropped
		@(negedge clk);
		clkEnable = 0;
		ptrSel = s;
		loadHigh = 1;
		loadData = ~v[15:8];
		@(negedge clk);
		clkEnable = 1;
		loadData = v[15:8];
		@(negedge clk);
		loadHigh = 0;
		loadLow = 1;
		loadData = v[7:0];
		@(negedge clk);
		loadLow = 0;
		accessValid = 1;
		accessSel = s;
		accessWrite = w;
		useMode = u;
		stepMode = m;
		offset = o;
		writeData = v[7:0] ^ 8'h3C;
		@(negedge clk);
		accessValid = 0;
		repeat (3) @(negedge clk);
		a = u ? (m[1] ? v : m[0] ? v - 16'h0001 : v + 16'h0001) : v + {{10{o[5]}}, o};
		chk(s ? pointer1 : pointer0, u ? (m[0] ? v - 16'h0001 : v + 16'h0001) : v);
		if (!w) chk({8'h00, lastRes}, {8'h00, er(a)});
	end
	endtask
	task give_verdict;
	begin
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		repeat (16) @(negedge clk);
		reset_n = 1;
		op(1, 0, 1, 2'h2, 6'h00, 16'h8010);
		op(0, 0, 1, 2'h3, 6'h00, 16'h0001);
		op(0, 1, 1, 2'h2, 6'h00, 16'hFFFF);
		op(1, 1, 1, 2'h3, 6'h00, 16'h0000);
		op(0, 1, 1, 2'h2, 6'h00, 16'h2345);
		op(0, 1, 1, 2'h2, 6'h00, 16'h0123);
		op(1, 0, 1, 2'h3, 6'h00, 16'h0FFF);
		op(1, 0, 1, 2'h0, 6'h00, 16'h7FFF);
		for (i = 0; i < 60; i = i + 1)
		begin
			rnd = xs(rnd);
			op(rnd[0], rnd[1], rnd[2], rnd[4:3], rnd[10:5], rnd[31:16]);
		end
		give_verdict;
	end
endmodule
